// [design/cce_config.sv]
// Custom charger emulation registers and stimulus 1 response engine.
`timescale 1ns/1ps
`default_nettype none
`include "cce_map.svh"

// Functional notes
// - Register contents survive sleep; only the reset clears them.
// - Profile is three stimuli each with its own response on data lines.
// - Custom timeout disable stops the timeout; global disable stops it too.
// - Ordering bit 1 puts the custom profile first, 0 last.
// - Profile disable bit excludes the profile; resets to one.
// - Reserved control bit reads zero; software never writes one.
// - Timer type 1 holds response for the timer; 0 delays it.
// - Delay field decodes to 0,1,5,10,20,40,80,100 milliseconds.
// - Trigger 000/111 bus voltage, 001/110 positive line, 011 negative.
// - Trigger 010 is a window on the positive line above a fixed floor.
// - Trigger codes 100 and 101 define no stimulus.
// - A write with magnitude 1111 is rejected, register unchanged.
// - Voltage responses read magnitude as voltage, 0000 meaning pull-down.
// - Resistor responses read magnitude as resistor value.
// - Divider responses read magnitude as minimum divider resistance.
// - Response select picks voltage, resistor, divider, link or removal.
// - Codes 1110/1111 keep reset pull-downs on 000, drop them on 111.
// - On trigger 000, untargeted lines keep their reset pull-downs.
// - Pull-down current field applies when a voltage response is pull-down.
// - Threshold field drives data-line comparators, unused for 000/111.
module cce_config #(
  parameter int TICK_CYCLES = `CCE_TICK_US * `CCE_CLK_MHZ
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              global_timeout_disable,
  input  wire logic              profile_start,
  input  wire logic              profile_stop,
  input  wire cce_pkg::cce_sense_s sense_pins,
  output logic                   custom_enabled,
  output logic                   custom_order_first,
  output logic                   stim_detected,
  output logic                   response_active,
  output logic [3:0]             response_select,
  output logic [3:0]             response_magnitude,
  output logic [1:0]             pulldown_current,
  output logic                   pulldown_mode,
  output logic [3:0]             threshold,
  output logic                   threshold_used,
  output logic                   dp_reset_pulldown,
  output logic                   dm_reset_pulldown,
  output logic                   profile_accepted,
  output logic                   timeout_expired
);
  cce_pkg::cce_ctrl_s  ctrl, next_ctrl;
  cce_pkg::cce_trig_s  trig, next_trig;
  cce_pkg::cce_resp_s  resp, next_resp;
  cce_pkg::cce_thr_s   thr, next_thr;
  logic [7:0]          next_rdata;
  cce_pkg::cce_sense_s s1, s2, s3, sense, next_sense;
  cce_pkg::cce_state_e state, next_state;
  logic [17:0]         tick_cnt, next_tick_cnt;
  logic [6:0]          td_cnt, next_td_cnt;
  logic [13:0]         to_cnt, next_to_cnt;
  logic                next_active, next_dp_pd, next_dm_pd;
  logic                next_accepted, next_expired;
  logic                ms_tick, hit, timeout_on, engaged;
  logic [6:0]          td_ms;
  logic [13:0]         to_ms;
  logic                tgt_dp, tgt_dm, keep_code;

  localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

  // Register writes and reads; sleep has no reset path here.
  always_comb begin
    next_ctrl  = ctrl;
    next_trig  = trig;
    next_resp  = resp;
    next_thr   = thr;
    next_rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        `CCE_ADDR_CTRL: next_ctrl = reg_wdata & `CCE_MASK_CTRL;
        `CCE_ADDR_TRIG: next_trig = reg_wdata & `CCE_MASK_TRIG;
        `CCE_ADDR_RESP: begin
          if (reg_wdata[7:`CCE_MAG_LSB] != `CCE_MAG_BAD) begin
            next_resp = reg_wdata;
          end
        end
        `CCE_ADDR_THR:  next_thr = reg_wdata & `CCE_MASK_THR;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `CCE_ADDR_CTRL: next_rdata = ctrl;
        `CCE_ADDR_TRIG: next_rdata = trig;
        `CCE_ADDR_RESP: next_rdata = resp;
        `CCE_ADDR_THR:  next_rdata = thr;
        default:        next_rdata = 8'h00;
      endcase
    end else begin
      next_rdata = reg_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl      <= `CCE_RST_CTRL;
      trig      <= `CCE_RST_TRIG;
      resp      <= `CCE_RST_RESP;
      thr       <= `CCE_RST_THR;
      reg_rdata <= 8'h00;
    end else begin
      ctrl      <= next_ctrl;
      trig      <= next_trig;
      resp      <= next_resp;
      thr       <= next_thr;
      reg_rdata <= next_rdata;
    end
  end

  // Analog comparator levels pass three flops; a change counts on agreement.
  always_comb begin
    next_sense = sense;
    if (s2 == s3) begin
      next_sense = s3;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      sense <= '0;
    end else begin
      s1    <= sense_pins;
      s2    <= s1;
      s3    <= s2;
      sense <= next_sense;
    end
  end

  // Stimulus decode.
  always_comb begin
    case (trig.stim1_trigger_select)
      3'h0:    stim_detected = sense.vbus_ready;
      3'h1:    stim_detected = sense.dp_above_th;
      3'h2:    stim_detected = !sense.dp_above_th && sense.dp_above_floor;
      3'h3:    stim_detected = sense.dm_above_th;
      3'h6:    stim_detected = sense.dp_above_th;
      3'h7:    stim_detected = sense.vbus_present;
      default: stim_detected = 1'b0;
    endcase
  end

  // Delay and timeout lookups.
  always_comb begin
    case (trig.stim1_delay_select)
      3'h0:    td_ms = `CCE_TD0_MS;
      3'h1:    td_ms = `CCE_TD1_MS;
      3'h2:    td_ms = `CCE_TD2_MS;
      3'h3:    td_ms = `CCE_TD3_MS;
      3'h4:    td_ms = `CCE_TD4_MS;
      3'h5:    td_ms = `CCE_TD5_MS;
      3'h6:    td_ms = `CCE_TD6_MS;
      default: td_ms = `CCE_TD7_MS;
    endcase
    case (ctrl.custom_timeout_select)
      2'h0:    to_ms = `CCE_TO0_MS;
      2'h1:    to_ms = `CCE_TO1_MS;
      2'h2:    to_ms = `CCE_TO2_MS;
      default: to_ms = `CCE_TO3_MS;
    endcase
  end

  // Which lines the response claims.
  always_comb begin
    tgt_dp = 1'b0;
    tgt_dm = 1'b0;
    keep_code = 1'b0;
    case (resp.stim1_response_select)
      4'h1, 4'h4, 4'h6:       tgt_dp = 1'b1;
      4'h2, 4'h7, 4'h9:       tgt_dm = 1'b1;
      4'h3, 4'hA, 4'hC, 4'hD: begin
        tgt_dp = 1'b1;
        tgt_dm = 1'b1;
      end
      4'hE, 4'hF:             keep_code = 1'b1;
      default: ;
    endcase
  end

  // Custom disable wins over global in neither direction: either stops it.
  assign timeout_on = !(ctrl.custom_timeout_disable ||
                        global_timeout_disable);
  assign ms_tick    = (tick_cnt == TICK_LAST);
  assign hit        = ms_tick && (td_cnt + 7'h01 >= td_ms);
  assign engaged    = (state != cce_pkg::CCE_IDLE);

  always_comb begin
    next_state    = state;
    next_tick_cnt = engaged ? (ms_tick ? 18'h0 : tick_cnt + 18'h1) : 18'h0;
    next_td_cnt   = td_cnt;
    next_to_cnt   = to_cnt;
    next_active   = response_active;
    next_dp_pd    = dp_reset_pulldown;
    next_dm_pd    = dm_reset_pulldown;
    next_accepted = 1'b0;
    next_expired  = 1'b0;
    if (ms_tick && (td_cnt != 7'h7F)) begin
      next_td_cnt = td_cnt + 7'h01;
    end
    if (ms_tick && timeout_on && engaged) begin
      next_to_cnt = to_cnt + 14'h1;
    end
    case (state)
      cce_pkg::CCE_IDLE: begin
        next_active = 1'b0;
        if (profile_start && !ctrl.custom_profile_disable) begin
          next_state  = cce_pkg::CCE_ARM;
          next_to_cnt = 14'h0;
          next_dp_pd  = 1'b1;
          next_dm_pd  = 1'b1;
        end
      end
      cce_pkg::CCE_ARM: begin
        next_td_cnt = 7'h0;
        if (stim_detected) begin
          if (trig.stim1_timer_type) begin
            next_active = 1'b1;
            next_state  = cce_pkg::CCE_HOLD;
          end else begin
            next_state  = cce_pkg::CCE_DELAY;
          end
          // Reset pull-downs follow the claim on trigger 000; codes 1110/1111 keep them unless 111; other triggers drop both.
          if (keep_code) begin
            if (trig.stim1_trigger_select == 3'h7) begin
              next_dp_pd = 1'b0;
              next_dm_pd = 1'b0;
            end
          end else if (trig.stim1_trigger_select != 3'h0) begin
            next_dp_pd = 1'b0;
            next_dm_pd = 1'b0;
          end else begin
            next_dp_pd = dp_reset_pulldown && !tgt_dp;
            next_dm_pd = dm_reset_pulldown && !tgt_dm;
          end
        end
      end
      cce_pkg::CCE_DELAY: begin
        if (td_ms == 7'h0 || hit) begin
          next_active = 1'b1;
          next_state  = cce_pkg::CCE_DONE;
        end
      end
      cce_pkg::CCE_HOLD: begin
        // Held for the timer, then removed once the stimulus has gone.
        if ((td_ms == 7'h0 || hit || td_cnt >= td_ms) && !stim_detected) begin
          next_active = 1'b0;
          next_state  = cce_pkg::CCE_DONE;
        end
      end
      cce_pkg::CCE_DONE: ;
      cce_pkg::CCE_ACCEPT: ;
      default: next_state = cce_pkg::CCE_IDLE;
    endcase
    if (engaged && state != cce_pkg::CCE_ACCEPT && sense.ibus_above_chg) begin
      next_state    = cce_pkg::CCE_ACCEPT;
      next_accepted = 1'b1;
    end else if (engaged && state != cce_pkg::CCE_ACCEPT && timeout_on &&
                 to_cnt >= to_ms) begin
      next_state   = cce_pkg::CCE_IDLE;
      next_expired = 1'b1;
      next_active  = 1'b0;
    end
    if (profile_stop) begin
      next_state  = cce_pkg::CCE_IDLE;
      next_active = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state             <= cce_pkg::CCE_IDLE;
      tick_cnt          <= 18'h0;
      td_cnt            <= 7'h0;
      to_cnt            <= 14'h0;
      response_active   <= 1'b0;
      dp_reset_pulldown <= 1'b0;
      dm_reset_pulldown <= 1'b0;
      profile_accepted  <= 1'b0;
      timeout_expired   <= 1'b0;
    end else begin
      state             <= next_state;
      tick_cnt          <= next_tick_cnt;
      td_cnt            <= next_td_cnt;
      to_cnt            <= next_to_cnt;
      response_active   <= next_active;
      dp_reset_pulldown <= next_dp_pd;
      dm_reset_pulldown <= next_dm_pd;
      profile_accepted  <= next_accepted;
      timeout_expired   <= next_expired;
    end
  end

  // Settings handed to the analog response and comparator cells.
  assign custom_enabled     = !ctrl.custom_profile_disable;
  assign custom_order_first = ctrl.custom_order_first;
  assign response_select    = resp.stim1_response_select;
  assign response_magnitude = resp.stim1_response_magnitude;
  assign pulldown_current   = thr.stim1_pulldown_current;
  assign pulldown_mode      = response_active &&
    (resp.stim1_response_select inside {4'h1, 4'h2, 4'h3}) &&
    (resp.stim1_response_magnitude == 4'h0);
  assign threshold          = thr.stim1_threshold;
  assign threshold_used     = !(trig.stim1_trigger_select inside
                                {3'h0, 3'h7});

  chk_mag_reject: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `CCE_ADDR_RESP && reg_wdata[7:4] == 4'hF
    |=> $stable(resp)) else $error("bad magnitude was accepted");
  chk_rsv_zero: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == `CCE_ADDR_CTRL |=> reg_rdata[1] == 1'b0)
    else $error("reserved bit read as one");
  chk_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == `CCE_ADDR_THR |=> reg_rdata[7:6] == 2'h0)
    else $error("unimplemented bits read as one");
  chk_disabled_idle: assert property (@(posedge clk) disable iff (!rst_b)
    state == cce_pkg::CCE_IDLE && ctrl.custom_profile_disable
    |=> state == cce_pkg::CCE_IDLE) else $error("disabled profile ran");
  chk_to_frozen: assert property (@(posedge clk) disable iff (!rst_b)
    !timeout_on |=> !timeout_expired) else $error("timeout while disabled");
  chk_accept: assert property (@(posedge clk) disable iff (!rst_b)
    engaged && state != cce_pkg::CCE_ACCEPT && sense.ibus_above_chg &&
    !profile_stop |=> profile_accepted && state == cce_pkg::CCE_ACCEPT)
    else $error("charge current not accepted");
  chk_hold_apply: assert property (@(posedge clk) disable iff (!rst_b)
    state == cce_pkg::CCE_ARM && stim_detected && trig.stim1_timer_type &&
    !profile_stop && !sense.ibus_above_chg && !(timeout_on && to_cnt >= to_ms)
    |=> response_active) else $error("hold response not immediate");
  chk_delay_wait: assert property (@(posedge clk) disable iff (!rst_b)
    state == cce_pkg::CCE_DELAY && td_ms != 7'h0 && !hit
    |=> !response_active) else $error("delayed response too early");
  chk_window: assert property (@(posedge clk) disable iff (!rst_b)
    trig.stim1_trigger_select == 3'h2 && sense.dp_above_th
    |-> !stim_detected) else $error("window passed above threshold");
  chk_rsv_trig: assert property (@(posedge clk) disable iff (!rst_b)
    trig.stim1_trigger_select inside {3'h4, 3'h5} |-> !stim_detected)
    else $error("reserved trigger detected");
endmodule
`default_nettype wire

// [shared/cce_map.svh]
// Offsets, field positions, reset values and timing counts of the block.
`ifndef CCE_MAP_SVH
`define CCE_MAP_SVH
`define CCE_ADDR_CTRL     8'h40
`define CCE_ADDR_TRIG     8'h41
`define CCE_ADDR_RESP     8'h42
`define CCE_ADDR_THR      8'h43
`define CCE_RST_CTRL      8'h01
`define CCE_RST_TRIG      8'h00
`define CCE_RST_RESP      8'h00
`define CCE_RST_THR       8'h00
`define CCE_MASK_CTRL     8'h3D
`define CCE_MASK_TRIG     8'h7F
`define CCE_MASK_THR      8'h3F
`define CCE_MAG_LSB       4
`define CCE_MAG_BAD       4'hF
`define CCE_CLK_MHZ       250
`define CCE_TICK_US       1000
`define CCE_TD0_MS        7'h00
`define CCE_TD1_MS        7'h01
`define CCE_TD2_MS        7'h05
`define CCE_TD3_MS        7'h0A
`define CCE_TD4_MS        7'h14
`define CCE_TD5_MS        7'h28
`define CCE_TD6_MS        7'h50
`define CCE_TD7_MS        7'h64
`define CCE_TO0_MS        14'h0320
`define CCE_TO1_MS        14'h0640
`define CCE_TO2_MS        14'h1900
`define CCE_TO3_MS        14'h3200
`endif

// [shared/cce_pkg.sv]
// Types shared by the custom charger emulation configuration block.
package cce_pkg;
  typedef struct packed {
    logic [1:0] unused;
    logic       custom_timeout_disable;
    logic [1:0] custom_timeout_select;
    logic       custom_order_first;
    logic       reserved;
    logic       custom_profile_disable;
  } cce_ctrl_s;
  typedef struct packed {
    logic       unused;
    logic       stim1_timer_type;
    logic [2:0] stim1_delay_select;
    logic [2:0] stim1_trigger_select;
  } cce_trig_s;
  typedef struct packed {
    logic [3:0] stim1_response_magnitude;
    logic [3:0] stim1_response_select;
  } cce_resp_s;
  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] stim1_pulldown_current;
    logic [3:0] stim1_threshold;
  } cce_thr_s;
  typedef struct packed {
    logic vbus_ready;
    logic vbus_present;
    logic dp_above_th;
    logic dm_above_th;
    logic dp_above_floor;
    logic ibus_above_chg;
  } cce_sense_s;
  typedef enum logic [2:0] {
    CCE_IDLE, CCE_ARM, CCE_DELAY, CCE_HOLD, CCE_DONE, CCE_ACCEPT
  } cce_state_e;
endpackage

// [dv/cce_device_model.sv]
// Portable device model that drives the sensed port levels.
`timescale 1ns/1ps
`default_nettype none
module cce_device_model (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire cce_pkg::cce_sense_s want,
  input  wire logic [3:0]          lag,
  output var  cce_pkg::cce_sense_s sense_pins
);
  // The device reacts to requested levels after a lag, prompt or slow.
  cce_pkg::cce_sense_s q [16];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 16; i++) q[i] <= '0;
    end else begin
      q[0] <= want;
      for (int i = 1; i < 16; i++) q[i] <= q[i-1];
    end
  end
  assign sense_pins = q[lag];
endmodule
`default_nettype wire

// [dv/custom_charger_emulation_config_bench.sv]
// Self-checking bench for the custom charger emulation block.
`timescale 1ns/1ps
`default_nettype none
module custom_charger_emulation_config_bench;
  localparam int TK = 2;
  logic                clk, rst_b, wr, rd, gdis, start, stop;
  logic [7:0]          addr, wdata, rdata, rv, a, d;
  logic [3:0]          lag, rsel, rmag, thr;
  logic [1:0]          pdc;
  cce_pkg::cce_sense_s want, sense;
  logic                en, ofirst, sdet, ract, pdm, thu, dpp, dmp, acc, tex;
  logic [7:0]          shadow [4];
  logic [2:0]          cd [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  logic [7:0]          tt [4] = '{8'h00, 8'h00, 8'h07, 8'h07};
  logic [7:0]          rt [4] = '{8'h01, 8'h0E, 8'h0E, 8'h0F};
  logic [3:0]          ex [4] = '{4'h5, 4'hF, 4'hC, 4'hC};
  int                  tmo [4] = '{800, 1600, 6400, 12800};
  int                  fail_count, checked, seed, n, tos, lo, hi;

  cce_config #(.TICK_CYCLES(TK)) dut (.clk(clk), .rst_b(rst_b),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .global_timeout_disable(gdis),
    .profile_start(start), .profile_stop(stop), .sense_pins(sense),
    .custom_enabled(en), .custom_order_first(ofirst),
    .stim_detected(sdet), .response_active(ract),
    .response_select(rsel), .response_magnitude(rmag),
    .pulldown_current(pdc), .pulldown_mode(pdm), .threshold(thr),
    .threshold_used(thu), .dp_reset_pulldown(dpp),
    .dm_reset_pulldown(dmp), .profile_accepted(acc),
    .timeout_expired(tex));
  cce_device_model model (.clk(clk), .rst_b(rst_b), .want(want),
    .lag(lag), .sense_pins(sense));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(negedge clk) if (tex === 1'b1) tos++;

  task automatic stop_test();
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask

  function automatic logic [7:0] expw(input logic [1:0] i,
                                      input logic [7:0] v);
    case (i)
      2'h0: return v & 8'h3D;
      2'h1: return v & 8'h7F;
      2'h2: return (v[7:4] == 4'hF) ? shadow[2] : v;
      default: return v & 8'h3F;
    endcase
  endfunction

  function automatic logic exp_stim(input logic [2:0] c,
                                    input cce_pkg::cce_sense_s s);
    case (c)
      3'h0: return s.vbus_ready;
      3'h1, 3'h6: return s.dp_above_th;
      3'h2: return s.dp_above_floor & ~s.dp_above_th;
      3'h3: return s.dm_above_th;
      3'h7: return s.vbus_present;
      default: return 1'b0;
    endcase
  endfunction

  function automatic int dly_ms(input logic [2:0] c);
    int t [8] = '{0, 1, 5, 10, 20, 40, 80, 100};
    return t[c];
  endfunction

  task automatic wreg(input logic [7:0] ad, input logic [7:0] v);
    if (ad[7:2] == 6'h10) shadow[ad[1:0]] = expw(ad[1:0], v);
    @(posedge clk);
    addr <= ad;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] ad, output logic [7:0] v);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) v = rdata;
  endtask

  // Waits on negedges until the level shows, giving up after lim.
  task automatic wait_for(ref logic s, input logic v, input int lim,
                          output int k);
    k = 0;
    while (s !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic engage(input logic [7:0] c, input logic [7:0] t,
                        input logic [7:0] r);
    wreg(8'h40, c);
    wreg(8'h41, t);
    wreg(8'h42, r);
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    @(negedge clk);
  endtask

  task automatic disengage();
    @(posedge clk) want <= '0;
    @(posedge clk) stop <= 1'b1;
    @(posedge clk) stop <= 1'b0;
    repeat (24) @(negedge clk);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  initial begin
    rst_b = 1'b0; wr = 1'b0; rd = 1'b0; gdis = 1'b0; start = 1'b0;
    stop = 1'b0; addr = 8'h00; wdata = 8'h00; want = '0; lag = 4'h2;
    seed = 32'hE81C; tos = 0;
    shadow = '{8'h01, 8'h00, 8'h00, 8'h00};
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rreg(8'h40 + 8'(i), rv);
      chk(rv, (i < 4) ? shadow[i] : 8'h00);
    end
    for (int i = 0; i < 40; i++) begin
      a = 8'h40 | (8'($random(seed)) & 8'h03);
      d = 8'($random(seed));
      if (i == 7) a = 8'h42;
      if (i == 7) d = 8'hF3;
      if (a == 8'h40) d[1] = 1'b0;
      if (a == 8'h41 && d[2:1] == 2'b10) d[1] = 1'b1;
      wreg(a, d);
      @(negedge clk);
      chk({en, ofirst, pdc}, {~shadow[0][0], shadow[0][2], shadow[3][5:4]});
      chk({rmag, rsel}, shadow[2]);
      chk({thu, thr}, {!(shadow[1][2:0] inside {3'h0, 3'h7}), shadow[3][3:0]});
    end
    wreg(8'h44, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      rreg(8'h40 + 8'(i), rv);
      chk(rv, (i < 4) ? shadow[i] : 8'h00);
    end
    for (int i = 0; i < 24; i++) begin
      wreg(8'h41, {5'h00, cd[i % 6]});
      @(posedge clk) want <= cce_pkg::cce_sense_s'(6'($random(seed)));
      repeat (10) @(negedge clk);
      chk(8'(sdet), 8'(exp_stim(cd[i % 6], want)));
    end
    @(posedge clk) want <= '0;
    for (int c = 0; c < 8; c++) begin
      @(posedge clk) lag <= 4'(c + 1);
      engage(8'h20, {2'b00, 3'(c), 3'h1}, 8'h01);
      chk({dpp, dmp}, 8'h03);
      @(posedge clk) want.dp_above_th <= 1'b1;
      wait_for(ract, 1'b1, 400, n);
      lo = dly_ms(3'(c)) * TK + int'(lag) - 2;
      hi = dly_ms(3'(c)) * TK + int'(lag) + 12;
      chk(8'(n >= lo && n <= hi), 8'h01);
      chk({pdm, dpp, dmp}, 8'h04);
      @(posedge clk) want.ibus_above_chg <= 1'b1;
      wait_for(acc, 1'b1, 20, n);
      chk(8'(acc), 8'h01);
      disengage();
    end
    engage(8'h20, 8'h49, 8'h01);
    @(posedge clk) want.dp_above_th <= 1'b1;
    wait_for(ract, 1'b1, 40, n);
    chk(8'(n <= int'(lag) + 10), 8'h01);
    @(posedge clk) want.dp_above_th <= 1'b0;
    wait_for(ract, 1'b0, 60, n);
    chk(8'(ract), 8'h00);
    disengage();
    for (int i = 0; i < 4; i++) begin
      engage(8'h20, tt[i], rt[i]);
      @(posedge clk) want <= cce_pkg::cce_sense_s'(6'h30);
      wait_for(ract, 1'b1, 40, n);
      repeat (4) @(negedge clk);
      chk({dpp, dmp} & ex[i][3:2], ex[i][1:0]);
      disengage();
    end
    engage(8'h01, 8'h01, 8'h01);
    @(posedge clk) want <= cce_pkg::cce_sense_s'(6'h3F);
    wait_for(ract, 1'b1, 40, n);
    chk(8'(ract), 8'h00);
    disengage();
    for (int s = 0; s < 4; s++) begin
      engage({3'b000, 2'(s), 3'b000}, 8'h01, 8'h01);
      wait_for(tex, 1'b1, 30000, n);
      chk(8'(n >= tmo[s] * TK - 4 && n <= tmo[s] * TK + 8), 8'h01);
      disengage();
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) gdis <= (i > 0);
      tos = 0;
      engage((i == 1) ? 8'h00 : 8'h20, 8'h01, 8'h01);
      repeat (1700) @(negedge clk);
      chk(8'(tos), 8'h00);
      disengage();
    end
    @(posedge clk) gdis <= 1'b0;
    wreg(8'h40, 8'h00);
    rreg(8'h40, rv);
    chk(rv, shadow[0]);
    stop_test();
  end
endmodule
`default_nettype wire
